// File: pkg/gie_pkg.sv
// Purpose: Constants shared by the input pin interrupt enable block
// Assumes: Byte wide register file reached by the serial register engine
// Notes:   Offsets are register addresses on that engine
package gie_pkg;
    localparam int unsigned PIN_COUNT     = 19;
    localparam int unsigned REG_WIDTH     = 8;
    localparam int unsigned ADDR_WIDTH    = 8;
    localparam logic [7:0]  OFS_EN_LOW    = 8'h24;  // Pins 8 down to 1
    localparam logic [7:0]  OFS_EN_MID    = 8'h25;  // Pins 16 down to 9
    localparam logic [7:0]  OFS_EN_HIGH   = 8'h26;  // Pins 19 down to 17
    localparam int unsigned HIGH_BITS     = 3;      // Implemented bits of top register
    localparam logic [7:0]  EN_RESET      = 8'h00;
    localparam logic [2:0]  EN_HIGH_RESET = 3'h0;
    localparam logic [7:0]  RD_IDLE       = 8'h00;  // Unmapped address reads zero
endpackage : gie_pkg

// File: rtl/gie_input_irq_enable.sv
// Purpose: Per pin enable gating of latched input flags onto the summary flag
// Assumes: Flags, levels, polarity and FIFO routing come from neighbouring logic
// Notes:   Summary request is a level, one cycle behind its causes
//          It is not sticky; the status bit that holds it lives elsewhere
//          Enables reset to zero so no pin can interrupt before set-up
//
// How it works
// - Enabled pin with set flag and met condition sets summary flag (status 0x01 bit 1).
// - Disabled pin never contributes to the summary flag.
// - Register 0x24 read/write, bits 7..0 enable pins 8..1.
// - Register 0x25 read/write, bits 7..0 enable pins 16..9.
// - Register 0x26 bits 2..0 enable pins 19..17, bits 7..3 reserved.
// - Polarity select 0 means condition when pin low, 1 when high.
// - Pin routed to FIFO events never drives the summary flag.
`timescale 1ns/1ps
`default_nettype none
module gie_input_irq_enable #(
    parameter int unsigned PINS = gie_pkg::PIN_COUNT
) (
    input  wire logic                           clk_sys,        // System clock
    input  wire logic                           rst_n,          // Async reset, active low
    input  wire logic [gie_pkg::ADDR_WIDTH-1:0] regAddr,        // Register address
    input  wire logic [gie_pkg::REG_WIDTH-1:0]  regWrData,      // Write data
    input  wire logic                           regWrEn,        // Write strobe
    input  wire logic                           regRdEn,        // Read strobe
    input  wire logic [PINS-1:0]                pinLevel,       // Debounced pin levels
    input  wire logic [PINS-1:0]                pinFlag,        // Latched per pin flags
    input  wire logic [PINS-1:0]                polaritySelect, // Per pin level select
    input  wire logic [PINS-1:0]                fifoRoute,      // Per pin FIFO routing
    output logic      [gie_pkg::REG_WIDTH-1:0]  regRdData,      // Read data, registered
    output logic      [PINS-1:0]                pinIrqEnable,   // Enable bits
    output logic                                summaryIrqSet   // Summary flag set request
);
    import gie_pkg::*;

    logic [REG_WIDTH-1:0] enLow_ff;
    logic [REG_WIDTH-1:0] enMid_ff;
    logic [HIGH_BITS-1:0] enHigh_ff;
    logic [REG_WIDTH-1:0] rdData_ff;
    logic                 summary_ff;
    logic [REG_WIDTH-1:0] nxt_rdData;
    logic                 nxt_summary;
    logic [PINS-1:0]      enableVec;
    logic [PINS-1:0]      conditionMet;
    logic [PINS-1:0]      qualified;
    logic                 wrLow;
    logic                 wrMid;
    logic                 wrHigh;
    logic                 rdMapped;

    // Address match, shared by write and read paths
    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] ofs);
        hitReg = (a == ofs);
    endfunction : hitReg

    // Write decode
    assign wrLow  = regWrEn && hitReg(regAddr, OFS_EN_LOW);
    assign wrMid  = regWrEn && hitReg(regAddr, OFS_EN_MID);
    assign wrHigh = regWrEn && hitReg(regAddr, OFS_EN_HIGH);

    // Bit 0 of the low register is pin 1, straight concatenation keeps order
    assign enableVec = {enHigh_ff, enMid_ff, enLow_ff};

    // Per pin qualification; routing wins over the enable bit
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : gQual
            assign conditionMet[gi] = ~(pinLevel[gi] ^ polaritySelect[gi]);
            assign qualified[gi]    = pinFlag[gi] & conditionMet[gi]
                                    & enableVec[gi] & ~fifoRoute[gi];
        end
    endgenerate

    assign nxt_summary = |qualified;

    // Any of the three enable offsets; everything else reads idle
    assign rdMapped = hitReg(regAddr, OFS_EN_LOW) || hitReg(regAddr, OFS_EN_MID)
                    || hitReg(regAddr, OFS_EN_HIGH);

    // Read mux; reserved high bits read as zero, unmapped reads zero
    assign nxt_rdData = hitReg(regAddr, OFS_EN_LOW)  ? enLow_ff :
                        hitReg(regAddr, OFS_EN_MID)  ? enMid_ff :
                        hitReg(regAddr, OFS_EN_HIGH) ? {5'h00, enHigh_ff} :
                        RD_IDLE;

    // Enable registers; reserved write bits are dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enLow_ff  <= EN_RESET;
            enMid_ff  <= EN_RESET;
            enHigh_ff <= EN_HIGH_RESET;
        end else begin
            if (wrLow)  enLow_ff  <= regWrData;
            if (wrMid)  enMid_ff  <= regWrData;
            if (wrHigh) enHigh_ff <= regWrData[HIGH_BITS-1:0];
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= RD_IDLE;
        end else if (regRdEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    // Registered so the status register sees a glitch free request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            summary_ff <= 1'b0;
        end else begin
            summary_ff <= nxt_summary;
        end
    end

    assign regRdData     = rdData_ff;
    assign pinIrqEnable  = enableVec;
    assign summaryIrqSet = summary_ff;

    // Assertions share the one clock and sit out reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // A byte strobe aimed at the low enable register
    sequence writeLowSeq;
        regWrEn && regAddr == OFS_EN_LOW;
    endsequence

    // A byte strobe aimed at the middle enable register
    sequence writeMidSeq;
        regWrEn && regAddr == OFS_EN_MID;
    endsequence

    // A byte strobe aimed at the top enable register
    sequence writeHighSeq;
        regWrEn && regAddr == OFS_EN_HIGH;
    endsequence

    // A read strobe on the middle register with no write alongside
    sequence readMidSeq;
        regRdEn && regAddr == OFS_EN_MID && !regWrEn;
    endsequence

    // Pin 1 fully armed: flag, enable, condition met, not routed
    sequence pinOneArmedSeq;
        pinFlag[0] && enableVec[0] && !fifoRoute[0] && (pinLevel[0] == polaritySelect[0]);
    endsequence

    // Top pin armed with low polarity while its pin is held low
    sequence pinTopLowSeq;
        pinFlag[PINS-1] && enableVec[PINS-1] && !fifoRoute[PINS-1]
            && !polaritySelect[PINS-1] && !pinLevel[PINS-1];
    endsequence

    // Summary is exactly the qualified OR one cycle later
    summary_follow_a: assert property (summaryIrqSet == $past(|qualified))
        else $error("summary request does not follow qualified pins");

    // With every enable clear nothing may reach the summary
    disabled_quiet_a: assert property (enableVec == '0 |=> !summaryIrqSet)
        else $error("summary raised with every enable clear");

    // A raised summary must trace back to an enabled, unrouted, flagged pin
    summary_source_a: assert property (summaryIrqSet
        |-> $past(|(pinFlag & enableVec & ~fifoRoute)))
        else $error("summary raised without an enabled flagged pin");

    // Low register takes the whole byte
    low_write_a: assert property (writeLowSeq |=> enLow_ff == $past(regWrData))
        else $error("low enable register did not take write");

    // Low register reads back the value it held at the read edge
    low_read_a: assert property (regRdEn && regAddr == OFS_EN_LOW
        |=> regRdData == $past(enLow_ff))
        else $error("low enable register readback wrong");

    // Read data stands until the next read strobe
    read_hold_a: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without a read");

    // Enables change only through a write
    enable_hold_a: assert property (!regWrEn |=> $stable(pinIrqEnable))
        else $error("enable bits changed without a write");

    // Middle register takes the whole byte
    mid_take_a: assert property (writeMidSeq |=> enMid_ff == $past(regWrData))
        else $error("mid enable register did not take write");

    // Write, one idle cycle, then read back the same byte
    mid_write_a: assert property (writeMidSeq ##2 readMidSeq
        |=> regRdData == $past(regWrData, 3))
        else $error("mid enable register readback wrong");

    // Top register keeps only its three implemented bits
    high_take_a: assert property (writeHighSeq
        |=> enHigh_ff == $past(regWrData[HIGH_BITS-1:0]))
        else $error("high enable register did not take write");

    // Reserved bits of the top register always read zero
    high_resvd_a: assert property (regRdEn && regAddr == OFS_EN_HIGH
        |=> regRdData[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    // Top register reads back its implemented bits in place
    high_read_a: assert property (regRdEn && regAddr == OFS_EN_HIGH
        |=> regRdData == {5'h00, $past(enHigh_ff)})
        else $error("high enable register readback wrong");

    // Offsets outside the three enables read idle
    idle_read_a: assert property (regRdEn && !rdMapped |=> regRdData == RD_IDLE)
        else $error("unmapped read not idle");

    // Pin 1 is gated by bit zero of the low register
    pin_one_a: assert property (pinOneArmedSeq |=> summaryIrqSet)
        else $error("pin one flag not gated by bit zero");

    // Low polarity: a pin held low meets its condition
    polarity_a: assert property (pinTopLowSeq |=> summaryIrqSet)
        else $error("low polarity condition not honoured");

    // All pins routed to events leaves the summary quiet
    route_block_a: assert property (fifoRoute == '1 |=> !summaryIrqSet)
        else $error("FIFO routed pins drove summary");

    // Every enabled pin routed away leaves the summary quiet as well
    route_mask_a: assert property ((enableVec & ~fifoRoute) == '0
        |=> !summaryIrqSet)
        else $error("routed enabled pin drove summary");
endmodule : gie_input_irq_enable
`default_nettype wire

// File: tb/gie_pin_model.sv
// Purpose: Neighbour flag latch model for the input pins
// Assumes: A flag latches while the level meets its polarity
// Notes:   Flags stay set, so a met-then-lost condition is exercised
`timescale 1ns/1ps
`default_nettype none
module gie_pin_model (
    input  wire logic        clk_sys,        // System clock
    input  wire logic        rst_n,          // Async reset, active low
    input  wire logic [18:0] pinLevel,       // Pin levels
    input  wire logic [18:0] polaritySelect, // 1 = high active
    output logic      [18:0] pinFlag         // Latched flags
);
    logic [18:0] pinFlag_ff;
    // Sticky so a brief level is not lost
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) pinFlag_ff <= '0;
        else pinFlag_ff <= pinFlag_ff | ~(pinLevel ^ polaritySelect);
    end
    assign pinFlag = pinFlag_ff;
endmodule : gie_pin_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self checking bench for the input pin interrupt enable block
// Assumes: Byte strobes, read data one cycle after the read edge
// Notes:   Summary checked after a few cycles, flags lag one cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gie_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [18:0] pinLevel = '0, polaritySelect = '1, fifoRoute = '0, pinFlag, pinIrqEnable;
    logic        summaryIrqSet;
    int          numErrors = 0, testsRun = 0, cycles = 0;
    gie_input_irq_enable dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .pinLevel(pinLevel),
        .pinFlag(pinFlag), .polaritySelect(polaritySelect), .fifoRoute(fifoRoute),
        .regRdData(regRdData), .pinIrqEnable(pinIrqEnable), .summaryIrqSet(summaryIrqSet));
    gie_pin_model model_u (.clk_sys(clk_sys), .rst_n(rst_n), .pinLevel(pinLevel),
        .polaritySelect(polaritySelect), .pinFlag(pinFlag));
    // Clock and hang guard
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            numErrors++;
            testDone();
        end
    end
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : testDone
    task automatic check(string what, logic [18:0] exp, logic [18:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        @(negedge clk_sys);
        check("read data", {11'h0, exp}, {11'h0, regRdData});
    endtask : rd
    // Summary is a level one cycle behind, give it room
    task automatic settle(logic exp);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check("summary", {18'h0, exp}, {18'h0, summaryIrqSet});
        @(posedge clk_sys);
    endtask : settle
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) rd(OFS_EN_LOW + 8'(i), 8'h00);
        wr(OFS_EN_LOW, 8'hA5);
        wr(OFS_EN_HIGH, 8'hFF);
        wr(OFS_EN_MID, 8'h5A);
        rd(OFS_EN_MID, 8'h5A);
        rd(OFS_EN_LOW, 8'hA5);
        rd(OFS_EN_HIGH, 8'h07);
        rd(8'h27, 8'h00);
        check("enables", 19'h75AA5, pinIrqEnable);
        wr(OFS_EN_MID, 8'h00);
        wr(OFS_EN_HIGH, 8'h04);
        wr(OFS_EN_LOW, 8'h02);
        pinLevel <= 19'h00001;
        settle(1'b0);
        wr(OFS_EN_LOW, 8'h01);
        settle(1'b1);
        fifoRoute <= 19'h7FFFF;
        settle(1'b0);
        wr(OFS_EN_LOW, 8'h00);
        fifoRoute <= 19'h00000;
        polaritySelect <= 19'h3FFFF;
        pinLevel <= 19'h00000;
        settle(1'b1);
        pinLevel <= 19'h40000;
        settle(1'b0);
        testDone();
    end
endmodule : tb_top
`default_nettype wire
